// >>> mcu_instruction_decode_execute_bench.sv
`timescale 1ns/1ps
`default_nettype none

module mcu_instruction_decode_execute_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic int_taken = 1'b0;
  logic int_event = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] f_addr, f_wdata, bank, rdata;
  logic [15:0] pc;
  logic f_we, gid;
  logic [15:0] pmem [0:511];
  logic [7:0] fmem [0:255];
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  wire [15:0] instr = pmem[pc[8:0]];
  wire [7:0] f_rdata = fmem[f_addr];

  mide_core dut (
    .i_clk(clk), .i_rst_b(rst_b), .o_pc(pc), .i_instr(instr),
    .o_f_addr(f_addr), .i_f_rdata(f_rdata), .o_f_wdata(f_wdata),
    .o_f_we(f_we), .o_bank_select(bank), .i_int_taken(int_taken),
    .i_int_event(int_event), .o_global_int_disable(gid),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(rdata));

  // Clock
  always #25 clk = ~clk;

  // Cycle ceiling against a hung run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // File memory write port
  always @(posedge clk) if (f_we === 1'b1) fmem[f_addr] <= f_wdata;

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Sum with status nibble {OV,Z,DC,C} above the result byte
  function automatic int addf(int a, int b, int c);
    int r;
    r = a + b + c;
    return (r & 255) | (((r >> 8) & 1) << 8)
      | (int'((a & 15) + (b & 15) + c > 15) << 9)
      | (int'((r & 255) == 0) << 10)
      | (int'((a >> 7) == (b >> 7) && ((r >> 7) & 1) != (a >> 7)) << 11);
  endfunction

  // One operation under test, framed by setup and a sentinel
  task automatic run(int t);
    int w, fv, k, c, b, f, o, x, ew, ef, es, eb, sent, ep;
    logic [7:0] v;
    w = $urandom % 256;
    fv = $urandom % 256;
    k = $urandom % 256;
    c = $urandom % 2;
    b = $urandom % 8;
    f = 32 + $urandom % 64;
    case (t)
      0, 1: o = 32'h0E00 | (t << 8);
      2, 3: o = 32'h1000 | ((t - 2) << 8);
      4, 5: o = 32'h0C00 | ((t - 4) << 8);
      6: o = 32'hB500;
      7: o = 32'hB300;
      8: o = 32'hB400;
      9: o = 32'hB200;
      10: o = 32'hBC00;
      11: o = 32'hB800;
      12: o = 32'hBA00 | (c << 8);
      13: o = 32'h9800 | (b << 8);
      14: o = 32'h9000 | (b << 8);
      15: o = 32'hB740;
      16: o = 32'hE040;
      17: o = 32'h2800 | (c << 8);
      18: o = 32'h2A00 | (c << 8);
      19: o = 32'hAC00;
      20: o = 32'hA802;
      default: o = 32'hAC00;
    endcase
    if (t < 6 || t == 13 || t == 14 || (t > 16 && t < 19)) o = o | f;
    else if (t < 13) o = o | k;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    foreach (pmem[i]) pmem[i] = 16'h0000;
    foreach (fmem[i]) fmem[i] = 8'h00;
    pmem[0] = 16'hB0FF;
    pmem[1] = 16'(32'hB100 | c);
    pmem[2] = 16'(32'hB000 | w);
    pmem[3] = 16'(o);
    pmem[4] = 16'h8080;
    pmem[5] = 16'hC005;
    pmem[9'h040] = 16'h0005;
    pmem[9'h140] = 16'(32'hB600 | k);
    fmem[f] = 8'(fv);
    chk("reset pc", pc, 16'h0000);
    rst_b <= 1'b1;
    @(posedge clk);
    int_taken <= 1'b1;
    @(posedge clk);
    int_taken <= 1'b0;
    wr(3'h3, t == 15 ? 8'h01 : 8'h00);
    if (t == 19) wr(3'h5, 8'h01);
    chk("int disable set", gid, 16'h0001);
    repeat (80) @(posedge clk);
    // Expected state from the operation's definition
    ew = w;
    ef = fv;
    es = c ? 7 : 0;
    eb = 0;
    sent = 1;
    case (t)
      0, 1, 2, 3: begin
        x = addf(w, fv, t > 1 ? c : 0);
        es = x >> 8;
        if (t % 2) ef = x & 255;
        else ew = x & 255;
      end
      4, 5: x = w ^ fv;
      6: x = w & k;
      7: x = w | k;
      8: x = w ^ k;
      9: begin
        x = addf(k, 255 - w, 1);
        ew = x & 255;
        es = x >> 8;
      end
      11: eb = k & 15;
      12: eb = k & 240;
      13: sent = (fv >> b) & 1;
      14: sent = 1 - ((fv >> b) & 1);
      15: ew = k;
      19: sent = 0;
      17, 18: begin
        ef = t == 17 ? 0 : 255;
        if (c == 0) ew = ef;
      end
      default: x = 0;
    endcase
    if (t == 5) ef = x;
    if (t == 4 || (t > 5 && t < 9)) ew = x;
    if (t > 3 && t < 9) es = (es & 11) | (int'(x == 0) << 2);
    rd(3'h0, v);
    chk("working", v, ew);
    wr(3'h1, 8'hFF);
    rd(3'h1, v);
    chk("status", v, es);
    chk("file", fmem[f], ef);
    chk("bank", bank, eb);
    chk("sentinel", fmem[128], sent);
    // Loop phase at this point follows the cycle count of the operation
    ep = t == 19 ? 4 : ((t == 15 || t == 16 || t == 21) ? 5 : 6);
    chk("pc", pc, ep);
    chk("int disable", gid, t == 16 ? 0 : 1);
    if (t == 10) begin
      rd(3'h6, v);
      chk("product low", v, (w * k) & 255);
      rd(3'h7, v);
      chk("product high", v, (w * k) >> 8);
    end
    if (t == 19) begin
      @(posedge clk);
      int_event <= 1'b1;
      @(posedge clk);
      int_event <= 1'b0;
      repeat (20) @(posedge clk);
      chk("table write end", fmem[128], 16'h0001);
    end
    $display("Test %0d done", t);
  endtask

  // Main sequence
  initial begin
    int s;
    s = $urandom(32'h7DF1839F);
    repeat (3) @(posedge clk);
    for (int r = 0; r < 2; r++)
      for (int t = 0; t < 22; t++)
        run(t);
    tally_and_finish();
  end
endmodule // mcu_instruction_decode_execute_bench

`default_nettype wire

// >>> mide_alu.sv
`timescale 1ns/1ps
`default_nettype none

module mide_alu
  import mide_pkg::*;
#(
  parameter int W = 8
) (
  // Function and operands
  input wire mide_alu_e i_op,
  input wire logic [W-1:0] i_a,
  input wire logic [W-1:0] i_b,
  input wire logic i_cin,
  // Results
  output logic [W-1:0] o_res,
  output logic o_c,
  output logic o_dc,
  output logic o_ov,
  output logic [2*W-1:0] o_prod
);

  // Adder shared by add, add with carry and reverse subtract
  always_comb begin
    logic [W:0] sum;
    logic [4:0] nib;
    logic [W-1:0] bb;
    logic ci;
    sum = '0;
    nib = '0;
    bb = (i_op == ALU_SUB) ? ~i_b : i_b;
    ci = (i_op == ALU_SUB) ? 1'b1 : ((i_op == ALU_ADDC) ? i_cin : 1'b0);
    sum = {1'b0, i_a} + {1'b0, bb} + {{W{1'b0}}, ci};
    nib = {1'b0, i_a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    o_c = sum[W];
    o_dc = nib[4];
    o_ov = (i_a[W-1] == bb[W-1]) && (sum[W-1] != i_a[W-1]);
    case (i_op)
      ALU_ADD, ALU_ADDC, ALU_SUB: o_res = sum[W-1:0];
      ALU_AND: o_res = i_a & i_b;
      ALU_OR: o_res = i_a | i_b;
      ALU_XOR: o_res = i_a ^ i_b;
      default: o_res = i_b;
    endcase
  end

  // Unsigned 8 x 8 product
  assign o_prod = {{W{1'b0}}, i_a} * {{W{1'b0}}, i_b};

endmodule // mide_alu

`default_nettype wire

// >>> mide_consts.svh
`ifndef MIDE_CONSTS_SVH
`define MIDE_CONSTS_SVH

// Opcode patterns, matched with casez
`define MIDE_NOP_WORD 16'h0000
`define MIDE_P_ADD_FILE 16'b0000_111?_????_????
`define MIDE_P_ADD_FILE_CARRY 16'b0001_000?_????_????
`define MIDE_P_XOR_FILE 16'b0000_110?_????_????
`define MIDE_P_BIT_CLR 16'b1000_1???_????_????
`define MIDE_P_BIT_SET 16'b1000_0???_????_????
`define MIDE_P_SKIP_CLR 16'b1001_1???_????_????
`define MIDE_P_SKIP_SET 16'b1001_0???_????_????
`define MIDE_P_BIT_TGL 16'b0011_1???_????_????
`define MIDE_P_SKIP_ZERO 16'b0011_0011_????_????
`define MIDE_P_ADD_LIT 16'b1011_0001_????_????
`define MIDE_P_AND_LIT 16'b1011_0101_????_????
`define MIDE_P_OR_LIT 16'b1011_0011_????_????
`define MIDE_P_XOR_LIT 16'b1011_0100_????_????
`define MIDE_P_SUB_LIT 16'b1011_0010_????_????
`define MIDE_P_MOV_LIT 16'b1011_0000_????_????
`define MIDE_P_MUL_LIT 16'b1011_1100_????_????
`define MIDE_P_BANK_LO 16'b1011_1000_????_????
`define MIDE_P_BANK_HI 16'b1011_101?_????_????
`define MIDE_P_LONG_CALL 16'b1011_0111_????_????
`define MIDE_P_RET_LIT 16'b1011_0110_????_????
`define MIDE_P_CALL 16'b111?_????_????_????
`define MIDE_P_GOTO 16'b110?_????_????_????
`define MIDE_P_RET_INT 16'h0005
`define MIDE_P_RET 16'h0002
`define MIDE_P_TBL_RD 16'b1010_10??_????_????
`define MIDE_P_TBL_WR 16'b1010_11??_????_????
`define MIDE_P_CLR_FILE 16'b0010_100?_????_????
`define MIDE_P_SET_FILE 16'b0010_101?_????_????

// Opcode fields
`define MIDE_DEST_BIT 8
`define MIDE_BSEL_HI 10
`define MIDE_BSEL_LO 8
`define MIDE_FIELD_HI 7
`define MIDE_FIELD_LO 0
`define MIDE_JUMP_HI 12
`define MIDE_LATCH_HI 7
`define MIDE_LATCH_LO 5

// Status bit positions
`define MIDE_ST_C 0
`define MIDE_ST_DC 1
`define MIDE_ST_Z 2
`define MIDE_ST_OV 3

// Register port indices
`define MIDE_REG_WORK 3'h0
`define MIDE_REG_STATUS 3'h1
`define MIDE_REG_BANK 3'h2
`define MIDE_REG_PC_LATCH 3'h3
`define MIDE_REG_PC_LOW 3'h4
`define MIDE_REG_CTRL 3'h5
`define MIDE_REG_PROD_LO 3'h6
`define MIDE_REG_PROD_HI 3'h7
`define MIDE_CTRL_TBL_INT 0

// Reset values and misc
`define MIDE_RST_BYTE 8'h00
`define MIDE_RST_NIB 4'h0
`define MIDE_RST_PC 16'h0000
`define MIDE_ALL_ONES 8'hFF
`define MIDE_PC_LOW_FADDR 8'h02
`define MIDE_TBL_RD_PC_EXTRA 2'h1

`endif

// >>> mide_core.sv
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mide_consts.svh"

// Operation
// - A skip discards the prefetched instruction and runs a no-op instead
// - Conditional skips take two cycles when true, else one
// - Store-select 1 writes the file only; 0 writes working and file for clear/set file, working only for add and XOR
// - Long call loads PC high from the latch, low from literal
// - Internal table write waits for interrupt event; external takes two
// - Branches take two cycles; table read into PC low takes three
// - Add working to file, result to working or file, four flags
// - Add working, carry and file into destination, four flags
// - AND literal into working register, zero flag only
// - Return from interrupt takes two cycles, clears interrupt disable
// - Literal low nibble loads bank select low nibble
// - Literal high nibble loads bank select high nibble
// - Multiply literal by working register, one cycle, flags untouched
// - XOR literal into working register, zero flag only
// - OR literal into working register, zero flag only
// - Literal minus working into working, four flags
// - Return in two cycles loading literal into working register
// - XOR working with file into destination, zero flag only
// - Test file bit, skip next when clear
// - Test file bit, skip next when set

module mide_core
  import mide_pkg::*;
#(
  parameter int STACK_DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Program memory
  output logic [15:0] o_pc,
  input wire logic [15:0] i_instr,
  // File register memory
  output logic [7:0] o_f_addr,
  input wire logic [7:0] i_f_rdata,
  output logic [7:0] o_f_wdata,
  output logic o_f_we,
  output logic [7:0] o_bank_select,
  // Interrupt handshake
  input wire logic i_int_taken,
  input wire logic i_int_event,
  output logic o_global_int_disable,
  // Register port
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata
);

  localparam int SPW = $clog2(STACK_DEPTH);

  mide_phase_e q_r;
  logic [15:0] exec_r, pc_r;
  logic [7:0] w_r, bank_r, pc_latch_r, f_addr_r, opnd_r, res_r, rdata_r;
  logic [7:0] f_wdata_r;
  logic [3:0] status_r;
  logic [15:0] prod_r;
  logic c_r, dc_r, ov_r, skip_r, f_we_r, gid_r, twait_r, tbl_int_r;
  logic [1:0] extra_r;
  logic [15:0] stack_r [STACK_DEPTH];
  logic [SPW-1:0] sp_r;

  mide_op_e op_w;
  mide_alu_e alu_op_w;
  logic [7:0] alu_a_w, alu_res_w, res_w, mask_w;
  logic [15:0] prod_w;
  logic alu_c_w, alu_dc_w, alu_ov_w;
  logic lit_w, skip_w, wr_w_w, wr_f_w, arith_w, zonly_w, hold_w, at_q4;
  logic dest_f_w;

  // Opcode to operation class
  function automatic mide_op_e mide_decode(input logic [15:0] ins);
    casez (ins)
      `MIDE_P_RET_INT: mide_decode = OP_RET_INT;
      `MIDE_P_RET: mide_decode = OP_RET;
      `MIDE_P_ADD_FILE: mide_decode = OP_ADD_FILE;
      `MIDE_P_ADD_FILE_CARRY: mide_decode = OP_ADD_FILE_CARRY;
      `MIDE_P_XOR_FILE: mide_decode = OP_XOR_FILE;
      `MIDE_P_BIT_CLR: mide_decode = OP_BIT_CLR;
      `MIDE_P_BIT_SET: mide_decode = OP_BIT_SET;
      `MIDE_P_SKIP_CLR: mide_decode = OP_SKIP_CLR;
      `MIDE_P_SKIP_SET: mide_decode = OP_SKIP_SET;
      `MIDE_P_BIT_TGL: mide_decode = OP_BIT_TGL;
      `MIDE_P_SKIP_ZERO: mide_decode = OP_SKIP_ZERO;
      `MIDE_P_ADD_LIT: mide_decode = OP_ADD_LIT;
      `MIDE_P_AND_LIT: mide_decode = OP_AND_LIT;
      `MIDE_P_OR_LIT: mide_decode = OP_OR_LIT;
      `MIDE_P_XOR_LIT: mide_decode = OP_XOR_LIT;
      `MIDE_P_SUB_LIT: mide_decode = OP_SUB_LIT;
      `MIDE_P_MOV_LIT: mide_decode = OP_MOV_LIT;
      `MIDE_P_MUL_LIT: mide_decode = OP_MUL_LIT;
      `MIDE_P_BANK_LO: mide_decode = OP_BANK_LO;
      `MIDE_P_BANK_HI: mide_decode = OP_BANK_HI;
      `MIDE_P_LONG_CALL: mide_decode = OP_LONG_CALL;
      `MIDE_P_RET_LIT: mide_decode = OP_RET_LIT;
      `MIDE_P_CALL: mide_decode = OP_CALL;
      `MIDE_P_GOTO: mide_decode = OP_GOTO;
      `MIDE_P_TBL_RD: mide_decode = OP_TBL_RD;
      `MIDE_P_TBL_WR: mide_decode = OP_TBL_WR;
      `MIDE_P_CLR_FILE: mide_decode = OP_CLR_FILE;
      `MIDE_P_SET_FILE: mide_decode = OP_SET_FILE;
      default: mide_decode = OP_NOP;
    endcase
  endfunction

  // One-hot mask for a bit number
  function automatic logic [7:0] mide_bit_mask(input logic [2:0] b);
    mide_bit_mask = 8'h01 << b;
  endfunction

  // Decode of the executing instruction
  always_comb begin
    op_w = mide_decode(exec_r);
    mask_w = mide_bit_mask(exec_r[`MIDE_BSEL_HI:`MIDE_BSEL_LO]);
    dest_f_w = exec_r[`MIDE_DEST_BIT];
    lit_w = op_w inside {OP_ADD_LIT, OP_AND_LIT, OP_OR_LIT, OP_XOR_LIT,
                         OP_SUB_LIT, OP_MOV_LIT, OP_MUL_LIT, OP_BANK_LO,
                         OP_BANK_HI, OP_RET_LIT, OP_LONG_CALL};
    arith_w = op_w inside {OP_ADD_FILE, OP_ADD_FILE_CARRY, OP_ADD_LIT,
                           OP_SUB_LIT};
    zonly_w = op_w inside {OP_XOR_FILE, OP_AND_LIT, OP_OR_LIT, OP_XOR_LIT};
    hold_w = (extra_r != 2'h0) || twait_r;
    at_q4 = (q_r == MIDE_Q4);
  end

  // Destination select
  always_comb begin
    case (op_w)
      OP_ADD_FILE, OP_ADD_FILE_CARRY, OP_XOR_FILE: begin
        wr_w_w = !dest_f_w;
        wr_f_w = dest_f_w;
      end
      OP_CLR_FILE, OP_SET_FILE: begin
        wr_w_w = !dest_f_w;
        wr_f_w = 1'b1;
      end
      OP_BIT_CLR, OP_BIT_SET, OP_BIT_TGL: begin
        wr_w_w = 1'b0;
        wr_f_w = 1'b1;
      end
      OP_ADD_LIT, OP_AND_LIT, OP_OR_LIT, OP_XOR_LIT, OP_SUB_LIT,
      OP_MOV_LIT, OP_RET_LIT: begin
        wr_w_w = 1'b1;
        wr_f_w = 1'b0;
      end
      default: begin
        wr_w_w = 1'b0;
        wr_f_w = 1'b0;
      end
    endcase
  end

  // Arithmetic function select
  always_comb begin
    case (op_w)
      OP_ADD_FILE, OP_ADD_LIT: alu_op_w = ALU_ADD;
      OP_ADD_FILE_CARRY: alu_op_w = ALU_ADDC;
      OP_SUB_LIT: alu_op_w = ALU_SUB;
      OP_AND_LIT: alu_op_w = ALU_AND;
      OP_OR_LIT: alu_op_w = ALU_OR;
      OP_XOR_FILE, OP_XOR_LIT: alu_op_w = ALU_XOR;
      OP_MUL_LIT: alu_op_w = ALU_MUL;
      default: alu_op_w = ALU_PASS;
    endcase
    alu_a_w = (alu_op_w == ALU_SUB) ? opnd_r : w_r;
  end

  mide_alu #(.W(8)) u_alu (
    .i_op(alu_op_w),
    .i_a(alu_a_w),
    .i_b((alu_op_w == ALU_SUB) ? w_r : opnd_r),
    .i_cin(status_r[`MIDE_ST_C]),
    .o_res(alu_res_w),
    .o_c(alu_c_w),
    .o_dc(alu_dc_w),
    .o_ov(alu_ov_w),
    .o_prod(prod_w)
  );

  // Result and skip condition
  always_comb begin
    case (op_w)
      OP_BIT_CLR: res_w = opnd_r & ~mask_w;
      OP_BIT_SET: res_w = opnd_r | mask_w;
      OP_BIT_TGL: res_w = opnd_r ^ mask_w;
      OP_CLR_FILE: res_w = `MIDE_RST_BYTE;
      OP_SET_FILE: res_w = `MIDE_ALL_ONES;
      default: res_w = alu_res_w;
    endcase
    case (op_w)
      OP_SKIP_CLR: skip_w = (opnd_r & mask_w) == 8'h00;
      OP_SKIP_SET: skip_w = (opnd_r & mask_w) != 8'h00;
      OP_SKIP_ZERO: skip_w = (opnd_r == 8'h00);
      default: skip_w = 1'b0;
    endcase
  end

  // Phase sequencer
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      q_r <= MIDE_Q1;
    end else begin
      case (q_r)
        MIDE_Q1: q_r <= MIDE_Q2;
        MIDE_Q2: q_r <= MIDE_Q3;
        MIDE_Q3: q_r <= MIDE_Q4;
        MIDE_Q4: q_r <= MIDE_Q1;
        default: q_r <= MIDE_Q1;
      endcase
    end
  end

  // Decode phase addresses the file, read phase takes the operand
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      f_addr_r <= `MIDE_RST_BYTE;
      opnd_r <= `MIDE_RST_BYTE;
    end else if (q_r == MIDE_Q1) begin
      f_addr_r <= exec_r[`MIDE_FIELD_HI:`MIDE_FIELD_LO];
    end else if (q_r == MIDE_Q2) begin
      opnd_r <= lit_w ? exec_r[`MIDE_FIELD_HI:`MIDE_FIELD_LO] : i_f_rdata;
    end
  end

  // Process phase latches result, flags and skip
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      res_r <= `MIDE_RST_BYTE;
      f_wdata_r <= `MIDE_RST_BYTE;
      {c_r, dc_r, ov_r, skip_r} <= `MIDE_RST_NIB;
      f_we_r <= 1'b0;
    end else begin
      f_we_r <= (q_r == MIDE_Q3) && wr_f_w;
      if (q_r == MIDE_Q3) begin
        res_r <= res_w;
        f_wdata_r <= res_w;
        {c_r, dc_r, ov_r} <= {alu_c_w, alu_dc_w, alu_ov_w};
        skip_r <= skip_w;
      end
    end
  end

  // Write phase: working register, or software write when idle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      w_r <= `MIDE_RST_BYTE;
    end else if (at_q4 && wr_w_w) begin
      w_r <= res_r;
    end else if (i_reg_wr && i_reg_addr == `MIDE_REG_WORK) begin
      w_r <= i_reg_wdata;
    end
  end

  // Write phase: status flags
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      status_r <= `MIDE_RST_NIB;
    end else if (at_q4 && arith_w) begin
      status_r[`MIDE_ST_C] <= c_r;
      status_r[`MIDE_ST_DC] <= dc_r;
      status_r[`MIDE_ST_OV] <= ov_r;
      status_r[`MIDE_ST_Z] <= (res_r == 8'h00);
    end else if (at_q4 && zonly_w) begin
      status_r[`MIDE_ST_Z] <= (res_r == 8'h00);
    end
  end

  // Write phase: bank select and product
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bank_r <= `MIDE_RST_BYTE;
      prod_r <= `MIDE_RST_PC;
    end else if (at_q4) begin
      if (op_w == OP_BANK_LO) begin
        bank_r[3:0] <= opnd_r[3:0];
      end
      if (op_w == OP_BANK_HI) begin
        bank_r[7:4] <= opnd_r[7:4];
      end
      if (op_w == OP_MUL_LIT) begin
        prod_r <= prod_w;
      end
    end
  end

  // Interrupt disable: a taken interrupt wins over the clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      gid_r <= 1'b0;
    end else if (i_int_taken) begin
      gid_r <= 1'b1;
    end else if (at_q4 && op_w == OP_RET_INT) begin
      gid_r <= 1'b0;
    end
  end

  // Table stall state: extra no-op cycles and interrupt wait
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      extra_r <= 2'h0;
      twait_r <= 1'b0;
    end else begin
      if (at_q4 && hold_w && extra_r != 2'h0) begin
        extra_r <= extra_r - 2'h1;
      end else if (at_q4 && !hold_w && op_w == OP_TBL_RD &&
                   f_addr_r == `MIDE_PC_LOW_FADDR) begin
        extra_r <= `MIDE_TBL_RD_PC_EXTRA;
      end
      if (at_q4 && !hold_w && op_w == OP_TBL_WR && tbl_int_r) begin
        twait_r <= 1'b1;
      end else if (i_int_event) begin
        twait_r <= 1'b0;
      end
    end
  end

  // Fetch, program counter and call stack
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      exec_r <= `MIDE_NOP_WORD;
      pc_r <= `MIDE_RST_PC;
      sp_r <= '0;
    end else if (at_q4) begin
      exec_r <= `MIDE_NOP_WORD;
      if (hold_w) begin
        pc_r <= pc_r;
      end else if (skip_r) begin
        pc_r <= pc_r + 16'h0001;
      end else begin
        case (op_w)
          OP_GOTO: pc_r <= {pc_latch_r[`MIDE_LATCH_HI:`MIDE_LATCH_LO],
                            exec_r[`MIDE_JUMP_HI:0]};
          OP_CALL: begin
            stack_r[sp_r] <= pc_r;
            sp_r <= sp_r + 1'b1;
            pc_r <= {pc_latch_r[`MIDE_LATCH_HI:`MIDE_LATCH_LO],
                     exec_r[`MIDE_JUMP_HI:0]};
          end
          OP_LONG_CALL: begin
            stack_r[sp_r] <= pc_r;
            sp_r <= sp_r + 1'b1;
            pc_r <= {pc_latch_r, exec_r[`MIDE_FIELD_HI:`MIDE_FIELD_LO]};
          end
          OP_RET, OP_RET_INT, OP_RET_LIT: begin
            sp_r <= sp_r - 1'b1;
            pc_r <= stack_r[sp_r - 1'b1];
          end
          OP_TBL_RD, OP_TBL_WR: pc_r <= pc_r;
          default: begin
            exec_r <= i_instr;
            pc_r <= pc_r + 16'h0001;
          end
        endcase
      end
    end
  end

  // Software registers: latch and control
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pc_latch_r <= `MIDE_RST_BYTE;
      tbl_int_r <= 1'b0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `MIDE_REG_PC_LATCH) begin
        pc_latch_r <= i_reg_wdata;
      end
      if (i_reg_addr == `MIDE_REG_CTRL) begin
        tbl_int_r <= i_reg_wdata[`MIDE_CTRL_TBL_INT];
      end
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !i_reg_rd) begin
      rdata_r <= `MIDE_RST_BYTE;
    end else begin
      case (i_reg_addr)
        `MIDE_REG_WORK: rdata_r <= w_r;
        `MIDE_REG_STATUS: rdata_r <= {4'h0, status_r};
        `MIDE_REG_BANK: rdata_r <= bank_r;
        `MIDE_REG_PC_LATCH: rdata_r <= pc_latch_r;
        `MIDE_REG_PC_LOW: rdata_r <= pc_r[7:0];
        `MIDE_REG_CTRL: rdata_r <= {7'h00, tbl_int_r};
        `MIDE_REG_PROD_LO: rdata_r <= prod_r[7:0];
        `MIDE_REG_PROD_HI: rdata_r <= prod_r[15:8];
        default: rdata_r <= `MIDE_RST_BYTE;
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign o_pc = pc_r;
  assign o_f_addr = f_addr_r;
  assign o_f_wdata = f_wdata_r;
  assign o_f_we = f_we_r;
  assign o_bank_select = bank_r;
  assign o_global_int_disable = gid_r;
  assign o_reg_rdata = rdata_r;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_quad;
    q_r == MIDE_Q2 ##1 q_r == MIDE_Q3 ##1 q_r == MIDE_Q4 ##1 q_r == MIDE_Q1;
  endsequence

  sequence s_two_cycle;
    exec_r == `MIDE_NOP_WORD ##4 exec_r == $past(i_instr);
  endsequence

  a_phase_walk:
    assert property (q_r == MIDE_Q1 |=> s_quad)
    else $error("phase order broken");

  a_skip_nop_pc:
    assert property (at_q4 && !hold_w && skip_r |=>
      exec_r == `MIDE_NOP_WORD && pc_r - $past(pc_r) == 16'h0001)
    else $error("skip did not replace next with no-op");

  a_noskip_single:
    assert property (at_q4 && !hold_w && op_w == OP_SKIP_CLR && !skip_r
      |=> exec_r == $past(i_instr))
    else $error("false skip cost an extra cycle");

  a_store_sel_both:
    assert property (q_r == MIDE_Q3 && op_w == OP_CLR_FILE && !dest_f_w
      |=> o_f_we ##1 w_r == 8'h00)
    else $error("store-select 0 did not write both");

  a_long_call_pc:
    assert property (at_q4 && !hold_w && !skip_r && op_w == OP_LONG_CALL
      |=> pc_r == {$past(pc_latch_r), $past(exec_r[7:0])})
    else $error("long call target wrong");

  a_branch_two:
    assert property (at_q4 && !hold_w && !skip_r && op_w == OP_GOTO
      |=> s_two_cycle)
    else $error("branch not two cycles");

  a_add_dest_w:
    assert property (at_q4 && op_w == OP_ADD_FILE && !dest_f_w
      |=> w_r == $past(res_r) && !o_f_we)
    else $error("add to working register misrouted");

  a_ret_int_gid:
    assert property (at_q4 && op_w == OP_RET_INT && !i_int_taken
      |=> !o_global_int_disable)
    else $error("return from interrupt left disable set");

  a_bank_low:
    assert property (at_q4 && op_w == OP_BANK_LO |=>
      bank_r[3:0] == $past(opnd_r[3:0]) && $stable(bank_r[7:4]))
    else $error("bank low nibble load wrong");

  a_mul_no_flags:
    assert property (q_r == MIDE_Q3 && op_w == OP_MUL_LIT
      |=> ##1 $stable(status_r) && prod_r == $past(prod_w, 2))
    else $error("multiply touched flags or lost product");

endmodule // mide_core

`default_nettype wire

// >>> mide_pkg.sv
package mide_pkg;

  // Instruction cycle phases, Gray coded
  typedef enum logic [1:0] {
    MIDE_Q1 = 2'b00,
    MIDE_Q2 = 2'b01,
    MIDE_Q3 = 2'b11,
    MIDE_Q4 = 2'b10
  } mide_phase_e;

  // Decoded operation classes
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD_FILE, OP_ADD_FILE_CARRY, OP_XOR_FILE, OP_BIT_CLR,
    OP_BIT_SET, OP_SKIP_CLR, OP_SKIP_SET, OP_BIT_TGL, OP_SKIP_ZERO,
    OP_ADD_LIT, OP_AND_LIT, OP_OR_LIT, OP_XOR_LIT, OP_SUB_LIT,
    OP_MOV_LIT, OP_MUL_LIT, OP_BANK_LO, OP_BANK_HI, OP_CALL, OP_GOTO,
    OP_LONG_CALL, OP_RET, OP_RET_INT, OP_RET_LIT, OP_TBL_RD, OP_TBL_WR,
    OP_CLR_FILE, OP_SET_FILE
  } mide_op_e;

  // Arithmetic unit functions
  typedef enum logic [2:0] {
    ALU_PASS, ALU_ADD, ALU_ADDC, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_MUL
  } mide_alu_e;

endpackage
